/* File: rtl/async_serial_defs.vh */
/*
  Constants for the asynchronous serial port: register offsets, mode
  and status bit positions, parity codes and sampling ratio.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ASYNC_SERIAL_DEFS_VH
`define ASYNC_SERIAL_DEFS_VH

// register offsets on the plain register port
`define ADDR_MODE        4'h0
`define ADDR_STATUS      4'h1
`define ADDR_RXBUF       4'h2
`define ADDR_RXBUF_LOW   4'h3
`define ADDR_TXSHIFT     4'h4
`define ADDR_TXSHIFT_LOW 4'h5

// mode register fields
`define MODE_RESET       8'h00
`define MODE_RX_ENABLE   7
`define MODE_PAR_HI      6
`define MODE_PAR_LO      5
`define MODE_NINTH       4
`define MODE_CHAR_LEN    2
`define MODE_STOP_LEN    1
`define MODE_CLK_SEL     0

// parity codes
`define PAR_NONE         2'h0
`define PAR_ZERO         2'h1
`define PAR_ODD          2'h2
`define PAR_EVEN         2'h3

// character lengths in data bits
`define CHAR_7           4'h7
`define CHAR_8           4'h8
`define CHAR_9           4'h9

// data bits counted by the parity sum; the ninth bit never counts
`define PAR_MASK_7       9'h07F
`define PAR_MASK_8       9'h0FF

// status register fields
`define STAT_TX_ACTIVE   7
`define STAT_PARITY      2
`define STAT_FRAMING     1
`define STAT_LOST        0

// oversampling ratio and half point
`define OVERSAMPLE       5'h10
`define SAMPLE_MID       4'h7
`define SAMPLE_LAST      4'hF

`endif

/* File: rtl/async_serial_port.v */
/*
  Full-duplex asynchronous serial port: mode and status registers,
  9-bit receive buffer, 9-bit transmit shifter, 16x oversampled
  transmitter and receiver, three interrupt request pulses.
  Assumes rx_line is already synchronous to clk and the register port
  obeys one-cycle strobes with read data valid the cycle after.
*/
// Local design decisions: the strobed register port and the register offsets.
//
// Function
// - write to idle shifter starts a frame
// - transmit done request after whole frame
// - frame gets start and stop bits, and a parity bit unless parity is none
// - one or two stop bits
// - unused receive buffer bits read zero
// - sixteen-bit and low-byte aliases for both
// - enabled receiver copies frame to buffer
// - receive done with buffer load
// - errors set matching status flags
// - error flags clear on read or next
// - transmit flag high during transmission
// - disabled receiver ignores line, keeps buffer
// - enabled receiver starts on start bit
// - parity select encoding 00/01/10/11
// - even parity generation and check
// - odd parity generation and check
// - zero parity sends 0, never errors
// - no parity: no bit, no error
// - ninth bit only without parity
// - char length seven or eight bits
// - sample at sixteen times bit rate
// - missing stop bit is framing error
// - unread buffer overwritten, overrun flagged
`timescale 1ns/1ps
`include "async_serial_defs.vh"

module async_serial_port (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // external baud generator tick
  input  wire        baud_tick,
  // serial pins
  output reg         tx_line,
  input  wire        rx_line,
  // interrupt requests
  output reg         rx_done_irq,
  output reg         tx_done_irq,
  output reg         rx_error_irq
);

  localparam TX_IDLE  = 3'h0;
  localparam TX_START = 3'h1;
  localparam TX_DATA  = 3'h2;
  localparam TX_PAR   = 3'h3;
  localparam TX_STOP  = 3'h4;

  localparam RX_IDLE  = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA  = 3'h2;
  localparam RX_PAR   = 3'h3;
  localparam RX_STOP  = 3'h4;

  reg  [7:0] uart_mode_reg;
  reg  [8:0] rx_buffer;
  reg        parity_error_flag;
  reg        framing_error_flag;
  reg        rx_lost_flag;
  reg        tx_active_flag;
  reg        buf_unread_q;
  wire       tick;

  wire       rx_enable        = uart_mode_reg[`MODE_RX_ENABLE];
  wire [1:0] parity_select    = uart_mode_reg[`MODE_PAR_HI:`MODE_PAR_LO];
  wire       ninth_bit_enable = uart_mode_reg[`MODE_NINTH];
  wire       char_length      = uart_mode_reg[`MODE_CHAR_LEN];
  wire       two_stop         = uart_mode_reg[`MODE_STOP_LEN];

  // data bits per character
  wire       use_ninth = ninth_bit_enable && (parity_select == `PAR_NONE);
  wire [3:0] nbits     = use_ninth ? `CHAR_9 : (char_length ? `CHAR_8 : `CHAR_7);
  wire       has_par   = (parity_select != `PAR_NONE);

  serial_tick_gen u_tick (
    .clk          (clk),
    .rst_n        (rst_n),
    .half_clk_sel (uart_mode_reg[`MODE_CLK_SEL]),
    .baud_tick    (baud_tick),
    .tick         (tick)
  );

  // register access decode
  wire wr_mode = reg_wr && (reg_addr == `ADDR_MODE);
  wire wr_tx   = reg_wr && ((reg_addr == `ADDR_TXSHIFT) ||
                            (reg_addr == `ADDR_TXSHIFT_LOW));
  wire rd_buf  = reg_rd && ((reg_addr == `ADDR_RXBUF) ||
                            (reg_addr == `ADDR_RXBUF_LOW));
  // low-byte alias leaves the ninth bit at zero
  wire [8:0] tx_wr_val = (reg_addr == `ADDR_TXSHIFT) ? reg_wdata[8:0]
                                                     : {1'b0, reg_wdata[7:0]};

  // parity covers seven or eight data bits, never the ninth
  wire [8:0] par_mask = char_length ? `PAR_MASK_8 : `PAR_MASK_7;
  wire       wr_ones  = ^(tx_wr_val & par_mask);
  reg        tx_par_d;

  always @* begin
    case (parity_select)
      `PAR_ODD:  tx_par_d = ~wr_ones;
      `PAR_EVEN: tx_par_d = wr_ones;
      default:   tx_par_d = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uart_mode_reg <= `MODE_RESET;
    end else if (wr_mode) begin
      uart_mode_reg <= reg_wdata[7:0];
    end
  end

  // status byte: transmit flag on top, error flags at the bottom
  reg [7:0] status_byte;
  always @* begin
    status_byte                  = 8'h00;
    status_byte[`STAT_TX_ACTIVE] = tx_active_flag;
    status_byte[`STAT_PARITY]    = parity_error_flag;
    status_byte[`STAT_FRAMING]   = framing_error_flag;
    status_byte[`STAT_LOST]      = rx_lost_flag;
  end

  // read data stand one cycle only and are zero otherwise, so slaves can be ORed
  reg [15:0] rdata_d;
  always @* begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_MODE:      rdata_d = {8'h00, uart_mode_reg};
        `ADDR_STATUS:    rdata_d = {8'h00, status_byte};
        `ADDR_RXBUF:     rdata_d = {7'h00, rx_buffer};
        `ADDR_RXBUF_LOW: rdata_d = {8'h00, rx_buffer[7:0]};
        default:         rdata_d = 16'h0000;
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // transmitter
  reg [2:0] tx_state_q;
  reg [3:0] tx_phase_q;
  reg [3:0] tx_bit_q;
  reg [8:0] tx_shifter;
  reg       tx_par_q;

  // final data bit of the character being sent
  wire      tx_last_bit = (tx_bit_q == nbits - 4'h1);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_q     <= TX_IDLE;
      tx_phase_q     <= 4'h0;
      tx_bit_q       <= 4'h0;
      tx_shifter     <= 9'h000;
      tx_par_q       <= 1'b0;
      tx_line        <= 1'b1;
      tx_active_flag <= 1'b0;
      tx_done_irq    <= 1'b0;
    end else begin
      tx_done_irq <= 1'b0;
      // writes during a frame are dropped; software waits for the flag
      if (wr_tx && (tx_state_q == TX_IDLE)) begin
        tx_shifter     <= tx_wr_val;
        tx_state_q     <= TX_START;
        tx_phase_q     <= 4'h0;
        tx_active_flag <= 1'b1;
        tx_line        <= 1'b0;
        tx_par_q       <= tx_par_d;
      end else if (tick && (tx_state_q != TX_IDLE)) begin
        tx_phase_q <= tx_phase_q + 4'h1;
        if (tx_phase_q == `SAMPLE_LAST) begin
          case (tx_state_q)
            TX_START: begin
              tx_state_q <= TX_DATA;
              tx_bit_q   <= 4'h0;
              tx_line    <= tx_shifter[0];
            end
            TX_DATA: begin
              if (tx_last_bit) begin
                tx_state_q <= has_par ? TX_PAR : TX_STOP;
                tx_line    <= has_par ? tx_par_q : 1'b1;
                tx_bit_q   <= 4'h0;
              end else begin
                tx_bit_q   <= tx_bit_q + 4'h1;
                tx_shifter <= {1'b0, tx_shifter[8:1]};
                tx_line    <= tx_shifter[1];
              end
            end
            TX_PAR: begin
              tx_state_q <= TX_STOP;
              tx_bit_q   <= 4'h0;
              tx_line    <= 1'b1;
            end
            TX_STOP: begin
              if (two_stop && (tx_bit_q == 4'h0)) begin
                tx_bit_q <= 4'h1;
              end else begin
                tx_state_q     <= TX_IDLE;
                tx_active_flag <= 1'b0;
                tx_done_irq    <= 1'b1;
              end
            end
            default: tx_state_q <= TX_IDLE;
          endcase
        end
      end
    end
  end

  // receiver
  reg [2:0] rx_state_q;
  reg [3:0] rx_phase_q;
  reg [3:0] rx_bit_q;
  reg [8:0] rx_shift_q;
  reg       rx_ones_q;

  // final data bit of the character being received
  wire      rx_last_bit = (rx_bit_q == nbits - 4'h1);

  wire mid = tick && (rx_phase_q == `SAMPLE_MID);
  wire par_bad = ((parity_select == `PAR_EVEN) && (rx_ones_q ^ rx_line)) ||
                 ((parity_select == `PAR_ODD) && !(rx_ones_q ^ rx_line));
  reg  par_err_q;

  // error picture of the frame completing now; a same-cycle buffer read counts, so no overrun
  wire stop_bad = !rx_line;
  wire lost_now = buf_unread_q && !rd_buf;
  wire any_err  = par_err_q || stop_bad || lost_now;

  // frame completion flags, built in the stop state
  reg       done_d;
  reg [8:0] word_d;
  always @* begin
    done_d = 1'b0;
    word_d = rx_shift_q >> (`CHAR_9 - nbits);
    if ((rx_state_q == RX_STOP) && mid) begin
      done_d = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_q         <= RX_IDLE;
      rx_phase_q         <= 4'h0;
      rx_bit_q           <= 4'h0;
      rx_shift_q         <= 9'h000;
      rx_ones_q          <= 1'b0;
      par_err_q          <= 1'b0;
      rx_buffer          <= 9'h000;
      buf_unread_q       <= 1'b0;
      parity_error_flag  <= 1'b0;
      framing_error_flag <= 1'b0;
      rx_lost_flag       <= 1'b0;
      rx_done_irq        <= 1'b0;
      rx_error_irq       <= 1'b0;
    end else begin
      rx_done_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
      if (rd_buf) begin
        parity_error_flag  <= 1'b0;
        framing_error_flag <= 1'b0;
        rx_lost_flag       <= 1'b0;
        buf_unread_q       <= 1'b0;
      end
      if (!rx_enable) begin
        rx_state_q <= RX_IDLE;
      end else begin
        if (tick) begin
          rx_phase_q <= rx_phase_q + 4'h1;
        end
        case (rx_state_q)
          RX_IDLE: begin
            if (!rx_line) begin
              rx_state_q <= RX_START;
              rx_phase_q <= 4'h0;
            end
          end
          RX_START: begin
            if (mid) begin
              // glitch shorter than half a bit is not a start
              rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
              rx_bit_q   <= 4'h0;
              rx_ones_q  <= 1'b0;
            end
          end
          RX_DATA: begin
            if (mid) begin
              rx_shift_q <= {rx_line, rx_shift_q[8:1]};
              rx_ones_q  <= rx_ones_q ^ rx_line;
              rx_bit_q   <= rx_bit_q + 4'h1;
              if (rx_last_bit) begin
                rx_state_q <= has_par ? RX_PAR : RX_STOP;
              end
              par_err_q  <= 1'b0;
            end
          end
          RX_PAR: begin
            if (mid) begin
              par_err_q  <= par_bad;
              rx_state_q <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (done_d) begin
              rx_state_q         <= RX_IDLE;
              rx_buffer          <= word_d;
              rx_done_irq        <= 1'b1;
              buf_unread_q       <= 1'b1;
              // new frame replaces flags; set wins over a same-cycle read
              parity_error_flag  <= par_err_q;
              framing_error_flag <= stop_bad;
              rx_lost_flag       <= lost_now;
              rx_error_irq       <= any_err;
            end
          end
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

endmodule

/* File: rtl/serial_tick_gen.v */
/*
  Sixteen-times oversampling tick generator for the serial port.
  Assumes one synchronous clock; baud_tick is a one-cycle pulse from
  an outside baud generator when the half-clock source is not used.
*/
`timescale 1ns/1ps

module serial_tick_gen (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // source selection
  input  wire half_clk_sel,
  input  wire baud_tick,
  // oversampling tick
  output wire tick
);

  reg toggle_q;

  // half clock rate: one tick every second cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= ~toggle_q;
    end
  end

  assign tick = half_clk_sel ? toggle_q : baud_tick;

endmodule

/* File: verif/async_serial_port_chk.sv */
/*
  Pin-level assertions for the asynchronous serial port.
  Assumes bind to async_serial_port; bit timing is checked only with clk/2 sampling.
*/
`timescale 1ns/1ps
module async_serial_port_chk (
  // clock and reset
  input logic        clk,
  input logic        rst_n,
  // register port
  input logic [3:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  // serial pins and requests
  input logic        tx_line,
  input logic        rx_line,
  input logic        rx_done_irq,
  input logic        tx_done_irq,
  input logic        rx_error_irq
);
  logic [7:0] mode_q;
  // shadow of the mode register, rebuilt from bus writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      mode_q <= 8'h00;
    else if (reg_wr && reg_addr == 4'h0)
      mode_q <= reg_wdata[7:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  tx_pulse_a: assert property (tx_done_irq |=> !tx_done_irq)
    else $error("transmit done not a pulse");
  rx_pulse_a: assert property (rx_done_irq |=> !rx_done_irq)
    else $error("receive done not a pulse");
  err_done_a: assert property (rx_error_irq |-> rx_done_irq)
    else $error("error request without buffer load");
  rx_off_a: assert property (!mode_q[7] |-> !rx_done_irq)
    else $error("disabled receiver loaded buffer");
  start_len_a: assert property (mode_q[0] && $fell(tx_line) |-> !tx_line [*8])
    else $error("start bit too short");
  stop_high_a: assert property (mode_q[0] && tx_done_irq |-> $past(tx_line, 8) && tx_line)
    else $error("stop bit not high at frame end");
  rx_stop_a: assert property (rx_done_irq && !rx_error_irq |-> rx_line)
    else $error("clean load without stop bit");
endmodule

bind async_serial_port async_serial_port_chk u_chk (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_line(tx_line), .rx_line(rx_line),
  .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq), .rx_error_irq(rx_error_irq));

/* File: verif/async_serial_port_test.sv */
/*
  Self-checking bench for async_serial_port with a remote station model.
  Assumes 32 clocks per bit: mode bit 0 set, or baud_tick pulsing every other clock.
*/
`timescale 1ns/1ps
module async_serial_port_test;
  logic clk, rst_n, reg_wr, reg_rd, tx_line, rx_line, rx_done_irq, tx_done_irq, rx_error_irq;
  logic        baud_tick = 1'b0;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  int errors, total_checks, rx_cnt, tx_cnt, err_cnt;
  async_serial_port dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .baud_tick(baud_tick), .tx_line(tx_line), .rx_line(rx_line), .rx_done_irq(rx_done_irq),
    .tx_done_irq(tx_done_irq), .rx_error_irq(rx_error_irq));
  serial_station station (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // outside tick source at the same rate as the half-clock source
  always @(posedge clk) baud_tick <= ~baud_tick;
  always @(posedge clk) begin
    rx_cnt <= rx_cnt + int'(rx_done_irq);
    tx_cnt <= tx_cnt + int'(tx_done_irq);
    err_cnt <= err_cnt + int'(rx_error_irq);
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic test_regs;
    logic [15:0] q;
    rd(4'h0, q);
    chk("mode reset", 16'h0000, q);
    rd(4'hF, q);
    chk("unmapped", 16'h0000, q);
    chk("tx idle", 16'h0001, {15'h0, tx_line});
  endtask
  task automatic tx_case(input logic [7:0] m, input logic [3:0] a, input logic [15:0] d,
                         input int n, input logic [11:0] e);
    logic [11:0] got;
    logic [15:0] q;
    int t0;
    wr(4'h0, {8'h00, m});
    t0 = tx_cnt;
    fork
      station.grab(got, n);
      begin
        wr(a, d);
        rd(4'h1, q);
        chk("tx active", 16'h0080, q);
        wr(4'h4, 16'h0000); // refused while busy
      end
    join
    chk("tx not early", 16'(t0), 16'(tx_cnt));
    repeat (64) @(posedge clk);
    chk("tx frame", {4'h0, e}, {4'h0, got});
    chk("tx done", 16'(t0 + 1), 16'(tx_cnt));
    rd(4'h1, q);
    chk("tx ended", 16'h0000, q);
  endtask
  task automatic rx_case(input logic [7:0] m, input logic [11:0] f, input int n,
                         input logic [15:0] st, input logic [15:0] b, input int dn);
    logic [15:0] q;
    int d0, e0;
    wr(4'h0, {8'h00, m});
    d0 = rx_cnt;
    e0 = err_cnt;
    station.send(f, n);
    repeat (8) @(posedge clk);
    chk("rx done", 16'(d0 + dn), 16'(rx_cnt));
    chk("rx err irq", 16'(e0 + int'(dn != 0 && st[2:0] != 3'h0)), 16'(err_cnt));
    rd(4'h1, q);
    chk("rx status", st, q);
    rd(4'h2, q);
    chk("rx buffer", b, q);
    rd(4'h1, q);
    chk("rx cleared", 16'h0000, q);
  endtask
  task automatic test_tx;
    tx_case(8'hE7, 4'h5, 16'h00A5, 12, {2'b11, 1'b0, 8'hA5, 1'b0});
    tx_case(8'hC1, 4'h5, 16'h00B5, 10, {1'b1, 1'b1, 7'h35, 1'b0});
    tx_case(8'hA5, 4'h5, 16'h00FF, 11, {1'b1, 1'b0, 8'hFF, 1'b0});
    tx_case(8'h95, 4'h4, 16'h01C3, 11, {1'b1, 9'h1C3, 1'b0});
    tx_case(8'h95, 4'h5, 16'h01C3, 11, {1'b1, 9'h0C3, 1'b0});
    tx_case(8'hF7, 4'h4, 16'h01A5, 12, {2'b11, 1'b0, 8'hA5, 1'b0});
    tx_case(8'hE6, 4'h5, 16'h00A5, 12, {2'b11, 1'b0, 8'hA5, 1'b0});
  endtask
  task automatic test_rx;
    logic [15:0] q;
    rx_case(8'hC1, {1'b1, 1'b1, 7'h35, 1'b0}, 10, 16'h0000, 16'h0035, 1);
    rx_case(8'hC1, {1'b1, 1'b0, 7'h35, 1'b0}, 10, 16'h0004, 16'h0035, 1);
    rx_case(8'hE7, {2'b11, 1'b1, 8'hA5, 1'b0}, 12, 16'h0004, 16'h00A5, 1);
    rx_case(8'hA5, {1'b1, 1'b1, 8'h3C, 1'b0}, 11, 16'h0000, 16'h003C, 1);
    rx_case(8'h95, {1'b1, 9'h1C3, 1'b0}, 11, 16'h0000, 16'h01C3, 1);
    rd(4'h3, q);
    chk("rx low alias", 16'h00C3, q);
    wr(4'h0, 16'h00C1);
    station.send({1'b1, 1'b0, 7'h35, 1'b0}, 10);
    rx_case(8'hC1, {1'b1, 1'b1, 7'h12, 1'b0}, 10, 16'h0001, 16'h0012, 1);
    rx_case(8'h01, {1'b1, 1'b1, 7'h35, 1'b0}, 10, 16'h0000, 16'h0012, 0);
    rx_case(8'hC1, {1'b0, 1'b1, 7'h35, 1'b0}, 10, 16'h0002, 16'h0035, 1);
  endtask
  initial begin
    {errors, total_checks, rx_cnt, tx_cnt, err_cnt} = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    test_tx();
    test_rx();
    finish_test();
  end
  // whole run is about 6000 clocks
  initial begin
    #400000;
    errors++;
    finish_test();
  end
endmodule

/* File: verif/serial_station.sv */
/*
  Remote serial station: sends frames onto the port's input, captures its output.
  Assumes 16 ticks per bit and a tick every other clock, so one bit lasts 32 clocks.
*/
`timescale 1ns/1ps
module serial_station (
  // clock
  input  logic clk,
  // serial lines
  input  logic tx_line,
  output logic rx_line
);
  localparam int BIT_CLKS = 32;
  initial rx_line = 1'b1;
  // frame bits given lsb first, stops included
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) rx_line <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk) rx_line <= 1'b1;
  endtask
  // samples at bit centres after the falling start edge
  task automatic grab(output logic [11:0] f, input int n);
    f = '0;
    @(negedge tx_line);
    repeat (BIT_CLKS / 2) @(posedge clk);
    // returns in the middle of the last bit, before the frame has ended
    for (int i = 0; i < n; i++) begin
      if (i > 0)
        repeat (BIT_CLKS) @(posedge clk);
      f[i] = tx_line;
    end
  endtask
endmodule
